// ==== hdl/bank_strobe_pkg.sv ====
// Purpose: constants for the dram bank strobe decode
// Assumes: 32-bit local address, four row strobes
// Notes: bank size field encodings and address bit positions
package bank_strobe_pkg;
    // ==========================================
    // bank size field
    localparam int SIZE_FIELD_HI = 2;
    localparam int SIZE_FIELD_LO = 1;
    localparam int INTERLEAVE_BIT = 0;
    localparam logic [1:0] SIZE_1MB = 2'h0;
    localparam logic [1:0] SIZE_4MB = 2'h1;
    localparam logic [1:0] SIZE_16MB = 2'h2;
    localparam logic [1:0] SIZE_64MB = 2'h3;
    // ==========================================
    // lowest bank select bit for each size
    localparam int SEL_LO_1MB = 20;
    localparam int SEL_LO_4MB = 22;
    localparam int SEL_LO_16MB = 24;
    localparam int SEL_LO_64MB = 26;
    // ==========================================
    // strobes and reset values
    localparam int NUM_STROBES = 4;
    localparam logic [3:0] STROBES_IDLE_N = 4'hf;
    localparam logic [3:0] PAIR_LOW = 4'h3;
    localparam logic [3:0] PAIR_HIGH = 4'hc;
    localparam logic [3:0] ONE_STROBE = 4'h1;
    localparam logic [31:0] BOOT_RECORD_ADDR = 32'hfeffff30;
    localparam logic [31:0] CONFIG_RESET = 32'h00000000;
    localparam logic [31:0] BASE_RESET = 32'h00000000;
endpackage : bank_strobe_pkg

// ==== hdl/bank_select_decode.sv ====
// Purpose: combinational choice of row strobes from an address
// Assumes: size code and interleave flag already registered
// Notes: active high one-hot or pair output
`timescale 1ns/100ps
module bank_select_decode
    import bank_strobe_pkg::*;
(
    // decode inputs
    input wire logic [31:0] addr_in,
    input wire logic [1:0] size_in,
    input wire logic interleave_in,
    // decode result
    output logic [NUM_STROBES-1:0] select_out,
    output logic [1:0] bank_bits_out
);
    // ==========================================
    // bank bit extraction
    function automatic logic [1:0] bank_bits(input logic [31:0] a, input logic [1:0] s);
        logic [1:0] r;
        r = a[SEL_LO_1MB +: 2];
        if (s == SIZE_4MB) begin
            r = a[SEL_LO_4MB +: 2];
        end else if (s == SIZE_16MB) begin
            r = a[SEL_LO_16MB +: 2];
        end else if (s == SIZE_64MB) begin
            r = a[SEL_LO_64MB +: 2];
        end
        return r;
    endfunction : bank_bits

    // absolute address bits, never base-relative
    wire logic [1:0] bits_w = bank_bits(addr_in, size_in);
    wire logic [3:0] single_w = ONE_STROBE << bits_w;
    wire logic [3:0] pair_w = bits_w[1] ? PAIR_HIGH : PAIR_LOW;

    assign bank_bits_out = bits_w;
    assign select_out = interleave_in ? pair_w : single_w;
endmodule : bank_select_decode

// ==== hdl/dram_bank_strobe_decode.sv ====
// Purpose: drive dram row strobes from local bus address
// Assumes: one clock domain, access request from local bus logic
// Notes: config and base words loaded by local bus config port
//        bank bits come from the absolute address, so a base that is
//        not on a four-bank boundary can strobe an empty bank
//        strap pin is resynchronised and read once after reset
`timescale 1ns/100ps
// Summary of operation
// - supports one to four dram banks, each on its own row strobe
// - two-bit size field picks 1, 4, 16 or 64 mbyte banks
// - bank bits are the two address bits just above bank size
// - non-interleaved: bank bits select exactly one strobe
// - interleaved: 00/01 drive pair 1:0, 10/11 drive pair 3:2
// - decode uses absolute address, not offset from the base
// - boot fetch after reset goes to fixed boot record address
module dram_bank_strobe_decode
    import bank_strobe_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // configuration load
    input wire logic config_write_in,
    input wire logic [31:0] config_data_in,
    input wire logic base_write_in,
    input wire logic [31:0] base_data_in,
    input wire logic boot_from_dram_in,
    // access request
    input wire logic access_start_in,
    input wire logic access_end_in,
    input wire logic [31:0] access_addr_in,
    // dram strobes
    output logic row_strobe0_n_out,
    output logic row_strobe1_n_out,
    output logic row_strobe2_n_out,
    output logic row_strobe3_n_out,
    // status
    output logic access_busy_out,
    output logic boot_fetch_pending_out,
    output logic [31:0] dram_bank_config_reg_out,
    output logic [31:0] dram_region_base_reg_out
);
    // ==========================================
    // state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } access_state_e;

    // state and strobes
    access_state_e state_reg, state_next;
    logic [3:0] strobe_n_reg, strobe_n_next;
    // configuration words
    logic [31:0] dram_bank_config_reg;
    logic [31:0] dram_region_base_reg;
    // boot strap chain and boot fetch flag
    logic strap_meta_reg;
    logic strap_sync_reg;
    logic strap_hold_reg;
    logic strap_taken_reg;
    logic boot_fetch_reg;
    // decode result, active high
    logic [3:0] select_w;

    // ==========================================
    // handshake qualifiers
    // a start while busy or an end while idle is dropped, never queued
    wire logic in_idle_w = (state_reg == ST_IDLE);
    wire logic in_access_w = (state_reg == ST_ACCESS);
    wire logic start_take_w = in_idle_w & access_start_in;
    wire logic end_take_w = in_access_w & access_end_in;

    // ==========================================
    // decode
    // first fetch after a dram boot is forced to the boot record
    // limitation: that address has the upper bank bit set at every
    // size, so a dram boot always opens strobe 2 or 3
    wire logic use_boot_w = boot_fetch_reg;
    wire logic [31:0] decode_addr_w = use_boot_w ? BOOT_RECORD_ADDR : access_addr_in;
    wire logic [1:0] size_w = dram_bank_config_reg[SIZE_FIELD_HI:SIZE_FIELD_LO];
    wire logic interleave_w = dram_bank_config_reg[INTERLEAVE_BIT];
    wire logic [3:0] strobe_load_n_w = ~select_w;

    bank_select_decode u_decode (
        .addr_in(decode_addr_w),
        .size_in(size_w),
        .interleave_in(interleave_w),
        .select_out(select_w),
        .bank_bits_out()
    );

    // ==========================================
    // next state
    // one-hot codes: any stray code falls back to idle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_take_w) begin
                    state_next = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (end_take_w) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // next strobes
    // strobes load on the start edge and hold until the end edge
    always_comb begin
        strobe_n_next = strobe_n_reg;
        case (state_reg)
            ST_IDLE: begin
                strobe_n_next = STROBES_IDLE_N;
                if (start_take_w) begin
                    strobe_n_next = strobe_load_n_w;
                end
            end
            ST_ACCESS: begin
                if (end_take_w) begin
                    strobe_n_next = STROBES_IDLE_N;
                end
            end
            default: begin
                strobe_n_next = STROBES_IDLE_N;
            end
        endcase
    end

    // ==========================================
    // state and strobe registers
    // strobes come straight from flops so the pins never glitch
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strobe_n_reg <= STROBES_IDLE_N;
        end else begin
            strobe_n_reg <= strobe_n_next;
        end
    end

    // ==========================================
    // configuration words
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dram_bank_config_reg <= CONFIG_RESET;
        end else if (config_write_in) begin
            dram_bank_config_reg <= config_data_in;
        end
    end

    // base is stored and read back only; no alignment check,
    // placing it on a four-bank boundary is left to software
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dram_region_base_reg <= BASE_RESET;
        end else if (base_write_in) begin
            dram_region_base_reg <= base_data_in;
        end
    end

    // ==========================================
    // boot strap pin
    // board pin, so three flops; no reset here, which lets the
    // chain fill while reset is still held low
    always_ff @(posedge clk_in) begin
        strap_meta_reg <= boot_from_dram_in;
        strap_sync_reg <= strap_meta_reg;
        strap_hold_reg <= strap_sync_reg;
    end

    // the strap counts once the last two stages agree
    wire logic strap_agree_w = (strap_sync_reg == strap_hold_reg);
    wire logic strap_load_w = !strap_taken_reg & strap_agree_w;

    // ==========================================
    // boot fetch flag
    // the strap load wins over an access start in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_taken_reg <= 1'b0;
            boot_fetch_reg <= 1'b0;
        end else if (strap_load_w) begin
            strap_taken_reg <= 1'b1;
            boot_fetch_reg <= strap_hold_reg;
        end else if (start_take_w) begin
            boot_fetch_reg <= 1'b0;
        end
    end

    // ==========================================
    // outputs
    // strobe pins, one per bank
    assign row_strobe0_n_out = strobe_n_reg[0];
    assign row_strobe1_n_out = strobe_n_reg[1];
    assign row_strobe2_n_out = strobe_n_reg[2];
    assign row_strobe3_n_out = strobe_n_reg[3];
    // status and read-back words
    assign access_busy_out = in_access_w;
    assign boot_fetch_pending_out = boot_fetch_reg;
    assign dram_bank_config_reg_out = dram_bank_config_reg;
    assign dram_region_base_reg_out = dram_region_base_reg;
endmodule : dram_bank_strobe_decode

// ==== tb/strobe_props.sv ====
// Purpose: strobe decode checks
// Assumes: one clock, async low reset
// Notes: expected strobes rebuilt here
`timescale 1ns/100ps
module strobe_props
    import bank_strobe_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic access_start_in,
    input wire logic access_end_in,
    input wire logic [31:0] access_addr_in,
    input wire logic row_strobe0_n_out,
    input wire logic row_strobe1_n_out,
    input wire logic row_strobe2_n_out,
    input wire logic row_strobe3_n_out,
    input wire logic access_busy_out,
    input wire logic boot_fetch_pending_out,
    input wire logic [31:0] dram_bank_config_reg_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [3:0] s_n;
    logic [3:0] exp_w;
    logic [3:0] boot_w;
    logic go;
    logic il;
    function automatic logic [3:0] dec(input logic [31:0] a, input logic [2:0] c);
        logic [1:0] b;
        b = 2'(a >> (20 + 2 * c[2:1]));
        return c[0] ? (b[1] ? 4'hc : 4'h3) : 4'h1 << b;
    endfunction : dec
    assign s_n = {row_strobe3_n_out, row_strobe2_n_out, row_strobe1_n_out, row_strobe0_n_out};
    assign go = access_start_in && !access_busy_out;
    assign il = dram_bank_config_reg_out[0];
    assign exp_w = dec(access_addr_in, dram_bank_config_reg_out[2:0]);
    assign boot_w = dec(BOOT_RECORD_ADDR, dram_bank_config_reg_out[2:0]);
    // ==========
    // assertions
    idle_high_a: assert property (!access_busy_out |-> s_n == 4'hf) else $error("strobe low when idle");
    decode_a: assert property (go && !boot_fetch_pending_out |=> ~s_n == $past(exp_w)) else $error("bad decode");
    boot_a: assert property (go && boot_fetch_pending_out |=> ~s_n == $past(boot_w)) else $error("bad boot");
    one_hot_a: assert property (access_busy_out && !il |-> $onehot(~s_n)) else $error("not one strobe");
    pair_a: assert property (access_busy_out && il |-> ~s_n inside {4'h3, 4'hc}) else $error("bad pair");
    hold_a: assert property (access_busy_out && !access_end_in |=> $stable(s_n) && access_busy_out)
        else $error("strobe moved");
    release_a: assert property (access_busy_out && access_end_in |=> s_n == 4'hf && !access_busy_out)
        else $error("no release");
    busy_low_a: assert property (go |=> access_busy_out && s_n != 4'hf) else $error("no strobe");
    cover property (go && il);
    cover property (go && boot_fetch_pending_out);
    cover property (access_busy_out && access_end_in);
endmodule : strobe_props

// ==== tb/dram_bank_model.sv ====
// Purpose: dram banks behind the row strobes
// Assumes: strobes active low
// Notes: remembers which rows opened last
`timescale 1ns/100ps
module dram_bank_model (
    input wire logic clk_in,
    input wire logic [3:0] strobe_n_in,
    output logic [3:0] hit_out
);
    // only a driven strobe opens a row
    always_ff @(posedge clk_in) begin
        if (strobe_n_in != 4'hf) begin
            hit_out <= ~strobe_n_in;
        end
    end
endmodule : dram_bank_model

// ==== tb/dram_bank_strobe_decode_tb.sv ====
// Purpose: bench for the strobe decode
// Assumes: 125 mhz clock
// Notes: expectations from the size table
`timescale 1ns/100ps
module dram_bank_strobe_decode_tb;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic config_write_in = 1'b0;
    logic [31:0] config_data_in = 32'h0;
    logic base_write_in = 1'b0;
    logic [31:0] base_data_in = 32'h0;
    logic boot_from_dram_in = 1'b0;
    logic access_start_in = 1'b0;
    logic access_end_in = 1'b0;
    logic [31:0] access_addr_in = 32'h0;
    logic row_strobe0_n_out, row_strobe1_n_out, row_strobe2_n_out, row_strobe3_n_out;
    logic access_busy_out, boot_fetch_pending_out;
    logic [31:0] dram_bank_config_reg_out, dram_region_base_reg_out;
    logic [3:0] hits;
    int bad_count = 0;
    int cmp_count = 0;
    wire [3:0] strobes = {row_strobe3_n_out, row_strobe2_n_out, row_strobe1_n_out, row_strobe0_n_out};
    dram_bank_strobe_decode dut (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .config_write_in(config_write_in),
        .config_data_in(config_data_in),
        .base_write_in(base_write_in),
        .base_data_in(base_data_in),
        .boot_from_dram_in(boot_from_dram_in),
        .access_start_in(access_start_in),
        .access_end_in(access_end_in),
        .access_addr_in(access_addr_in),
        .row_strobe0_n_out(row_strobe0_n_out),
        .row_strobe1_n_out(row_strobe1_n_out),
        .row_strobe2_n_out(row_strobe2_n_out),
        .row_strobe3_n_out(row_strobe3_n_out),
        .access_busy_out(access_busy_out),
        .boot_fetch_pending_out(boot_fetch_pending_out),
        .dram_bank_config_reg_out(dram_bank_config_reg_out),
        .dram_region_base_reg_out(dram_region_base_reg_out)
    );
    dram_bank_model banks (.clk_in(clk_in), .strobe_n_in(strobes), .hit_out(hits));
    always #4 clk_in = ~clk_in;
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rst(input logic s);
        @(posedge clk_in);
        boot_from_dram_in <= s;
        reset_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : rst
    task automatic wr(input logic [31:0] c, input logic [31:0] b);
        @(posedge clk_in);
        config_write_in <= 1'b1;
        base_write_in <= 1'b1;
        config_data_in <= c;
        base_data_in <= b;
        @(posedge clk_in);
        config_write_in <= 1'b0;
        base_write_in <= 1'b0;
        #1;
        chk(dram_bank_config_reg_out, c);
        chk(dram_region_base_reg_out, b);
    endtask : wr
    task automatic acc(input logic [31:0] a, input logic [3:0] exp);
        @(posedge clk_in);
        access_start_in <= 1'b1;
        access_addr_in <= a;
        @(posedge clk_in);
        access_start_in <= 1'b0;
        access_end_in <= 1'b1;
        @(posedge clk_in);
        access_end_in <= 1'b0;
        #1;
        chk(hits, exp);
        chk(strobes, 4'hf);
    endtask : acc
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // ==========
    // scenarios
    task automatic t_sizes(input logic il);
        for (int s = 0; s < 4; s++) begin
            wr(32'(s * 2) | 32'(il), 32'h0);
            for (int b = 0; b < 4; b++) begin
                acc(32'h80000010 | (32'(b) << (20 + 2 * s)), il ? ((b > 1) ? 4'hc : 4'h3) : 4'h1 << b);
            end
        end
    endtask : t_sizes
    task automatic t_remap;
        wr(32'h0, 32'hd0000000);
        acc(32'hd0001000, 4'h1);
        wr(32'h0, 32'hdfe00000);
        acc(32'hdfe01000, 4'h4);
        chk(dram_region_base_reg_out, 32'hdfe00000);
    endtask : t_remap
    task automatic t_boot;
        rst(1'b1);
        chk(boot_fetch_pending_out, 32'h1);
        wr(32'h2, 32'hfe800000);
        acc(32'h0, 4'h8);
        chk(boot_fetch_pending_out, 32'h0);
        acc(32'h0, 4'h1);
    endtask : t_boot
    initial begin
        rst(1'b0);
        chk(strobes, 4'hf);
        chk(dram_bank_config_reg_out, 32'h0);
        chk(boot_fetch_pending_out, 32'h0);
        t_sizes(1'b0);
        t_sizes(1'b1);
        t_remap();
        t_boot();
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        bad_count++;
        wrap_up();
    end
endmodule : dram_bank_strobe_decode_tb
bind dram_bank_strobe_decode strobe_props props_i (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .access_start_in(access_start_in),
    .access_end_in(access_end_in),
    .access_addr_in(access_addr_in),
    .row_strobe0_n_out(row_strobe0_n_out),
    .row_strobe1_n_out(row_strobe1_n_out),
    .row_strobe2_n_out(row_strobe2_n_out),
    .row_strobe3_n_out(row_strobe3_n_out),
    .access_busy_out(access_busy_out),
    .boot_fetch_pending_out(boot_fetch_pending_out),
    .dram_bank_config_reg_out(dram_bank_config_reg_out)
);
